// *** hw/dcs_ctrl_status_high.sv ***
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Register reached only via debug link read/write commands, not memory map.
// - Bits 7, 3, 2 written only by write command while unsecured.
// - Bit 5 writes ignored while in stop mode.
// - Bits 6, 1, 0 are read-only to host; hardware updates them.
// - Bit 7 is debug enable; set leaving reset in special single-chip.
// - Debug disabled: no active debug entry, restricted commands only.
// - Bit 6 set on active debug entry, cleared on exit, set leaving reset in special single-chip.
// - Debug enabled: bit 5 zero keeps link clock, one keeps all clocks.
// - Debug disabled: no stop influence, no communication during stop.
// - With handshaking, first acknowledge after stop entry is long.
// - With handshaking, bit 3 zero waits free cycle (512 timeout), one steals.
// - Without handshaking every debug access steals the next bus cycle; a request raised during a grant is dropped.
// - Bit 2 selects serial clock source; cleared by reset, sticky once set.
// - Bit 1 follows unsecured state; security bits changeable while set.
// - Bit 0 set only by mass-erase command; writes leave it alone.
// - Bit 0 cleared at erase end or soft reset; reads one while pending.
// - Debug-enabled stop entry/exit lengthened by two serial plus two bus cycles.
module dcs_ctrl_status_high
	import dcs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       soft_rst,
	input  wire logic       special_single_chip,
	input  wire logic       device_unsecured,
	input  wire logic       write_ctrl_status_cmd,
	input  wire logic       read_ctrl_status_cmd,
	input  wire logic [7:0] write_data,
	input  wire logic       mass_erase_cmd,
	input  wire logic       mass_erase_done,
	input  wire logic       active_debug_request,
	input  wire logic       active_debug_exit,
	input  wire logic       stop_request,
	input  wire logic       wake_request,
	input  wire logic       ack_enabled,
	input  wire logic       ack_pulse,
	input  wire logic       serial_clk_en,
	input  wire logic       access_req,
	input  wire logic       bus_free,
	input  wire logic       restricted_cmd,
	input  wire logic       link_cmd_valid,
	output logic [7:0]      read_data,
	output logic            read_valid,
	output logic            cmd_accept,
	output logic            active_debug_status,
	output logic            stop_link_clk_on,
	output logic            stop_all_clk_on,
	output logic            stop_mode,
	output logic            stop_granted,
	output logic            ack_long,
	output logic            bus_grant,
	output logic            bus_timeout,
	output logic            serial_clock_select,
	output logic            security_change_allowed,
	output logic            erase_pending
);

	//////////////////////////////////////////////////////////////////////////////
	// Register state

	logic debug_enable;
	logic next_debug_enable;
	logic stop_clock_policy;
	logic next_stop_clock_policy;
	logic bus_steal;
	logic next_bus_steal;
	logic next_serial_clock_select;
	logic next_active_debug_status;
	logic next_erase_pending;
	logic unsecured_status;
	logic next_unsecured_status;
	logic strap_pending;
	logic next_strap_pending;
	logic [7:0] next_read_data;
	logic next_read_valid;

	logic host_write;

	// Writes land only while unsecured; the register has no memory-map path
	assign host_write = write_ctrl_status_cmd && unsecured_status;

	always_comb begin
		next_strap_pending       = 1'b0;
		next_debug_enable        = debug_enable;
		next_stop_clock_policy   = stop_clock_policy;
		next_bus_steal           = bus_steal;
		next_serial_clock_select = serial_clock_select;
		next_active_debug_status = active_debug_status;
		next_erase_pending       = erase_pending;
		next_unsecured_status    = device_unsecured;
		if (strap_pending) begin
			// Mode strap is sampled on the first edge after reset release
			if (special_single_chip) begin
				next_debug_enable        = 1'b1;
				next_active_debug_status = 1'b1;
			end
		end else begin
			if (host_write) begin
				next_debug_enable = write_data[BIT_DEBUG_ENABLE];
				next_bus_steal    = write_data[BIT_BUS_STEAL];
				// Clock select can only be raised; lowering needs a reset
				if (write_data[BIT_SERIAL_CLKSEL]) begin
					next_serial_clock_select = 1'b1;
				end
				if (!stop_mode) begin
					next_stop_clock_policy = write_data[BIT_STOP_CLOCK];
				end
			end
			// Active status and erase bit ignore host data entirely
			if (active_debug_request && debug_enable) begin
				next_active_debug_status = 1'b1;
			end else if (active_debug_exit) begin
				next_active_debug_status = 1'b0;
			end
		end
		// Set beats clear if both arrive together
		if (mass_erase_cmd) begin
			next_erase_pending = 1'b1;
		end else if (mass_erase_done || soft_rst) begin
			next_erase_pending = 1'b0;
		end
		if (soft_rst) begin
			next_serial_clock_select = RST_SERIAL_CLKSEL;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strap_pending       <= 1'b1;
			debug_enable        <= RST_DEBUG_ENABLE;
			stop_clock_policy   <= RST_STOP_CLOCK;
			bus_steal           <= RST_BUS_STEAL;
			serial_clock_select <= RST_SERIAL_CLKSEL;
			active_debug_status <= RST_ACTIVE_DEBUG;
			erase_pending       <= RST_ERASE_PEND;
			unsecured_status    <= 1'b0;
		end else begin
			strap_pending       <= next_strap_pending;
			debug_enable        <= next_debug_enable;
			stop_clock_policy   <= next_stop_clock_policy;
			bus_steal           <= next_bus_steal;
			serial_clock_select <= next_serial_clock_select;
			active_debug_status <= next_active_debug_status;
			erase_pending       <= next_erase_pending;
			unsecured_status    <= next_unsecured_status;
		end
	end

	assign security_change_allowed = unsecured_status;

	//////////////////////////////////////////////////////////////////////////////
	// Read path

	always_comb begin
		next_read_data                    = 8'h00;
		next_read_data[BIT_DEBUG_ENABLE]  = debug_enable;
		next_read_data[BIT_ACTIVE_DEBUG]  = active_debug_status;
		next_read_data[BIT_STOP_CLOCK]    = stop_clock_policy;
		next_read_data[BIT_RESERVED]      = 1'b0;
		next_read_data[BIT_BUS_STEAL]     = bus_steal;
		next_read_data[BIT_SERIAL_CLKSEL] = serial_clock_select;
		next_read_data[BIT_UNSECURED]     = unsecured_status;
		next_read_data[BIT_ERASE_PEND]    = erase_pending;
		next_read_valid                   = read_ctrl_status_cmd;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			read_data  <= 8'h00;
			read_valid <= 1'b0;
		end else begin
			read_valid <= next_read_valid;
			if (next_read_valid) begin
				read_data <= next_read_data;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Command gating

	// Disabled unit accepts only the restricted set, and nothing during stop
	always_comb begin
		cmd_accept = 1'b0;
		if (link_cmd_valid) begin
			if (!debug_enable) begin
				cmd_accept = restricted_cmd && !stop_mode;
			end else begin
				cmd_accept = 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Stop sequencing

	dcs_stop_e                 stp_state;
	dcs_stop_e                 next_stp_state;
	logic [STOP_DLY_CNT_W-1:0] ser_cnt;
	logic [STOP_DLY_CNT_W-1:0] next_ser_cnt;
	logic [STOP_DLY_CNT_W-1:0] bus_cnt;
	logic [STOP_DLY_CNT_W-1:0] next_bus_cnt;
	logic                      long_ack_due;
	logic                      next_long_ack_due;
	logic                      dly_done;

	localparam logic [STOP_DLY_CNT_W-1:0] SER_N = STOP_DLY_CNT_W'(STOP_ACK_SERIAL_CYCLES);
	localparam logic [STOP_DLY_CNT_W-1:0] BUS_N = STOP_DLY_CNT_W'(STOP_ACK_BUS_CYCLES);

	assign dly_done = (ser_cnt == SER_N) && (bus_cnt == BUS_N);

	always_comb begin
		next_stp_state    = stp_state;
		next_ser_cnt      = ser_cnt;
		next_bus_cnt      = bus_cnt;
		next_long_ack_due = long_ack_due;
		case (stp_state)
			DCS_STP_RUN: begin
				if (stop_request) begin
					next_ser_cnt = '0;
					next_bus_cnt = '0;
					// A disabled unit adds no delay to stop
					next_stp_state = debug_enable ? DCS_STP_ENTER : DCS_STP_STOP;
					if (debug_enable && ack_enabled) begin
						next_long_ack_due = 1'b1;
					end
				end
			end
			DCS_STP_ENTER, DCS_STP_EXIT: begin
				// Serial edges counted first, then bus cycles
				if (ser_cnt != SER_N) begin
					if (serial_clk_en) begin
						next_ser_cnt = ser_cnt + 1'b1;
					end
				end else if (bus_cnt != BUS_N) begin
					next_bus_cnt = bus_cnt + 1'b1;
				end
				if (dly_done) begin
					next_stp_state = (stp_state == DCS_STP_ENTER) ? DCS_STP_STOP : DCS_STP_RUN;
				end
			end
			DCS_STP_STOP: begin
				if (wake_request) begin
					next_ser_cnt   = '0;
					next_bus_cnt   = '0;
					next_stp_state = debug_enable ? DCS_STP_EXIT : DCS_STP_RUN;
				end
			end
			default: begin
				next_stp_state = DCS_STP_RUN;
			end
		endcase
		if (ack_pulse && long_ack_due) begin
			next_long_ack_due = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stp_state    <= DCS_STP_RUN;
			ser_cnt      <= '0;
			bus_cnt      <= '0;
			long_ack_due <= 1'b0;
		end else begin
			stp_state    <= next_stp_state;
			ser_cnt      <= next_ser_cnt;
			bus_cnt      <= next_bus_cnt;
			long_ack_due <= next_long_ack_due;
		end
	end

	assign stop_mode    = (stp_state == DCS_STP_STOP);
	assign stop_granted = stop_mode;
	assign ack_long     = long_ack_due && ack_enabled;

	// Clock keep-alive only matters with the unit enabled
	assign stop_link_clk_on = debug_enable;
	assign stop_all_clk_on  = debug_enable && stop_clock_policy;

	//////////////////////////////////////////////////////////////////////////////
	// Bus access policy

	dcs_bus_arb u_bus_arb (
		.core_clk    (core_clk),
		.rst         (rst),
		.access_req  (access_req),
		.ack_enabled (ack_enabled),
		.steal_sel   (bus_steal),
		.bus_free    (bus_free),
		.bus_grant   (bus_grant),
		.bus_timeout (bus_timeout)
	);

endmodule : dcs_ctrl_status_high

// *** hw/dcs_pkg.sv ***
package dcs_pkg;

	// Bit positions within the high control byte
	localparam int unsigned BIT_DEBUG_ENABLE  = 7;
	localparam int unsigned BIT_ACTIVE_DEBUG  = 6;
	localparam int unsigned BIT_STOP_CLOCK    = 5;
	localparam int unsigned BIT_RESERVED      = 4;
	localparam int unsigned BIT_BUS_STEAL     = 3;
	localparam int unsigned BIT_SERIAL_CLKSEL = 2;
	localparam int unsigned BIT_UNSECURED     = 1;
	localparam int unsigned BIT_ERASE_PEND    = 0;

	// Values after reset of the control and status bits
	localparam logic        RST_DEBUG_ENABLE  = 1'b0;
	localparam logic        RST_STOP_CLOCK    = 1'b0;
	localparam logic        RST_BUS_STEAL     = 1'b0;
	localparam logic        RST_SERIAL_CLKSEL = 1'b0;
	localparam logic        RST_ACTIVE_DEBUG  = 1'b0;
	localparam logic        RST_ERASE_PEND    = 1'b0;

	// Free-cycle wait limit for a polite bus access
	localparam int unsigned BUS_WAIT_TIMEOUT_CYCLES = 512;
	localparam int unsigned BUS_WAIT_CNT_W          = 10;

	// Extra stop entry and exit delay: serial clock cycles plus bus cycles
	localparam int unsigned STOP_ACK_SERIAL_CYCLES = 2;
	localparam int unsigned STOP_ACK_BUS_CYCLES    = 2;
	localparam int unsigned STOP_DLY_CNT_W         = 3;

	// Host-side settle time after switching the serial clock source
	localparam int unsigned SERIAL_CLOCK_SELECT_SETTLE_CYCLES = 150;

	typedef enum logic [1:0] {
		DCS_BUS_IDLE  = 2'b00,
		DCS_BUS_WAIT  = 2'b01,
		DCS_BUS_GRANT = 2'b10
	} dcs_bus_e;

	typedef enum logic [1:0] {
		DCS_STP_RUN   = 2'b00,
		DCS_STP_ENTER = 2'b01,
		DCS_STP_STOP  = 2'b10,
		DCS_STP_EXIT  = 2'b11
	} dcs_stop_e;

endpackage : dcs_pkg

// *** hw/dcs_bus_arb.sv ***
`timescale 1ns/100ps
module dcs_bus_arb
	import dcs_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic access_req,
	input  wire logic ack_enabled,
	input  wire logic steal_sel,
	input  wire logic bus_free,
	output logic      bus_grant,
	output logic      bus_timeout
);

	dcs_bus_e                  state;
	dcs_bus_e                  next_state;
	logic [BUS_WAIT_CNT_W-1:0] wait_cnt;
	logic [BUS_WAIT_CNT_W-1:0] next_wait_cnt;
	logic                      next_timeout;

	localparam logic [BUS_WAIT_CNT_W-1:0] WAIT_LAST = BUS_WAIT_CNT_W'(BUS_WAIT_TIMEOUT_CYCLES - 1);

	always_comb begin
		next_state    = state;
		next_wait_cnt = wait_cnt;
		next_timeout  = 1'b0;
		case (state)
			DCS_BUS_IDLE: begin
				if (access_req) begin
					// Without handshaking the access always steals the next cycle
					if (!ack_enabled || steal_sel) begin
						next_state = DCS_BUS_GRANT;
					end else begin
						next_state    = DCS_BUS_WAIT;
						next_wait_cnt = '0;
					end
				end
			end
			DCS_BUS_WAIT: begin
				if (bus_free) begin
					next_state = DCS_BUS_GRANT;
				end else if (wait_cnt == WAIT_LAST) begin
					// Timeout forces the access rather than hanging the link
					next_state   = DCS_BUS_GRANT;
					next_timeout = 1'b1;
				end else begin
					next_wait_cnt = wait_cnt + 1'b1;
				end
			end
			DCS_BUS_GRANT: begin
				next_state = DCS_BUS_IDLE;
			end
			default: begin
				next_state = DCS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state       <= DCS_BUS_IDLE;
			wait_cnt    <= '0;
			bus_timeout <= 1'b0;
		end else begin
			state       <= next_state;
			wait_cnt    <= next_wait_cnt;
			bus_timeout <= next_timeout;
		end
	end

	assign bus_grant = (state == DCS_BUS_GRANT);

endmodule : dcs_bus_arb

// *** bench/dcs_host_model.sv ***
`timescale 1ns/100ps
// Host debug pod: issues register commands over the link, one at a time
module dcs_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] read_data,
	input  wire logic       read_valid,
	input  wire logic       cmd_accept,
	output logic            write_ctrl_status_cmd = 1'b0,
	output logic            read_ctrl_status_cmd = 1'b0,
	output logic [7:0]      write_data = 8'h00,
	output logic            link_cmd_valid = 1'b0,
	output logic            restricted_cmd = 1'b0
);
	task automatic wr(input logic [7:0] d);
		write_data = d;
		write_ctrl_status_cmd = 1'b1;
		@(posedge core_clk);
		#1;
		write_ctrl_status_cmd = 1'b0;
		// Released lines show the inverse so stale data never passes for valid
		write_data = ~d;
		// One idle edge at least, so two commands never meet in one time step
		repeat (d[2] ? 150 : 1) @(posedge core_clk);
		#1;
	endtask : wr

	task automatic rd(output logic [7:0] v);
		read_ctrl_status_cmd = 1'b1;
		@(posedge core_clk);
		#1;
		read_ctrl_status_cmd = 1'b0;
		v = read_valid ? read_data : 8'hXX;
		@(posedge core_clk);
		#1;
	endtask : rd

	task automatic cmd(input logic r, output logic a);
		restricted_cmd = r;
		link_cmd_valid = 1'b1;
		#1;
		a = cmd_accept;
		@(posedge core_clk);
		#1;
		link_cmd_valid = 1'b0;
		restricted_cmd = ~r;
		@(posedge core_clk);
		#1;
	endtask : cmd
endmodule : dcs_host_model

// *** bench/dcs_ctrl_status_high_assertions.sv ***
`timescale 1ns/100ps
module dcs_ctrl_status_high_checker (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       soft_rst,
	input wire logic       device_unsecured,
	input wire logic       write_ctrl_status_cmd,
	input wire logic       read_ctrl_status_cmd,
	input wire logic       mass_erase_cmd,
	input wire logic       mass_erase_done,
	input wire logic       stop_request,
	input wire logic       ack_enabled,
	input wire logic       access_req,
	input wire logic       restricted_cmd,
	input wire logic       link_cmd_valid,
	input wire logic [7:0] read_data,
	input wire logic       read_valid,
	input wire logic       cmd_accept,
	input wire logic       stop_link_clk_on,
	input wire logic       stop_all_clk_on,
	input wire logic       stop_mode,
	input wire logic       ack_long,
	input wire logic       bus_grant,
	input wire logic       serial_clock_select,
	input wire logic       security_change_allowed,
	input wire logic       erase_pending
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	//////////////////////////////////////////////////////////////////////////////
	rd_answer_a: assert property (read_ctrl_status_cmd |=> read_valid)
		else $error("read command not answered");
	zero_bit_a: assert property (read_valid |-> !read_data[4])
		else $error("bit 4 read as one");
	secure_wr_a: assert property (write_ctrl_status_cmd && !security_change_allowed |=> $stable(stop_link_clk_on))
		else $error("write taken while secured");
	clksel_sticky_a: assert property (serial_clock_select && !soft_rst |=> serial_clock_select)
		else $error("clock select cleared without reset");
	erase_set_a: assert property (mass_erase_cmd |=> erase_pending)
		else $error("erase command did not set pending");
	erase_hold_a: assert property (!erase_pending && !mass_erase_cmd |=> !erase_pending)
		else $error("erase pending set without command");
	erase_clr_a: assert property (mass_erase_done && !mass_erase_cmd |=> !erase_pending)
		else $error("erase pending not cleared at end");
	unsecured_status_track_a: assert property (1'b1 |=> security_change_allowed == $past(device_unsecured))
		else $error("unsecured bit does not follow device");
	stop_pol_a: assert property (stop_all_clk_on |-> stop_link_clk_on)
		else $error("all clocks kept with debug disabled");
	steal_now_a: assert property (access_req && !ack_enabled |=> bus_grant)
		else $error("access did not steal next cycle");
	cmd_gate_a: assert property (link_cmd_valid && !stop_link_clk_on && !restricted_cmd |-> !cmd_accept)
		else $error("full command accepted while disabled");
	plain_stop_a: assert property (stop_request && !stop_link_clk_on && !stop_mode |=> stop_mode)
		else $error("disabled unit delayed stop");
	long_ack_a: assert property (stop_request && ack_enabled && stop_link_clk_on && !stop_mode |=> ack_long)
		else $error("no long acknowledge after stop");
	cover property (stop_mode && stop_link_clk_on);
	cover property (erase_pending && read_valid);
	cover property (bus_grant && ack_enabled);
endmodule : dcs_ctrl_status_high_checker

bind dcs_ctrl_status_high dcs_ctrl_status_high_checker chk (
	.core_clk                (core_clk),
	.rst                     (rst),
	.soft_rst                (soft_rst),
	.device_unsecured        (device_unsecured),
	.write_ctrl_status_cmd   (write_ctrl_status_cmd),
	.read_ctrl_status_cmd    (read_ctrl_status_cmd),
	.mass_erase_cmd          (mass_erase_cmd),
	.mass_erase_done         (mass_erase_done),
	.stop_request            (stop_request),
	.ack_enabled             (ack_enabled),
	.access_req              (access_req),
	.restricted_cmd          (restricted_cmd),
	.link_cmd_valid          (link_cmd_valid),
	.read_data               (read_data),
	.read_valid              (read_valid),
	.cmd_accept              (cmd_accept),
	.stop_link_clk_on        (stop_link_clk_on),
	.stop_all_clk_on         (stop_all_clk_on),
	.stop_mode               (stop_mode),
	.ack_long                (ack_long),
	.bus_grant               (bus_grant),
	.serial_clock_select     (serial_clock_select),
	.security_change_allowed (security_change_allowed),
	.erase_pending           (erase_pending)
);

// *** bench/dcs_ctrl_status_high_tb.sv ***
`timescale 1ns/100ps
module dcs_ctrl_status_high_tb;
	import dcs_pkg::*;
	logic core_clk = 0, rst = 1, soft_rst = 0, special_single_chip = 1, device_unsecured = 1;
	logic mass_erase_cmd = 0, mass_erase_done = 0, active_debug_request = 0, active_debug_exit = 0;
	logic stop_request = 0, wake_request = 0, ack_enabled = 0, ack_pulse = 0, serial_clk_en = 1;
	logic access_req = 0, bus_free = 0, write_ctrl_status_cmd, read_ctrl_status_cmd, restricted_cmd;
	logic link_cmd_valid, read_valid, cmd_accept, active_debug_status, stop_link_clk_on, stop_all_clk_on;
	logic stop_mode, stop_granted, ack_long, bus_grant, bus_timeout, serial_clock_select;
	logic security_change_allowed, erase_pending, a;
	logic [7:0] write_data, read_data, v;
	int bad_count = 0, n_checks = 0, n;

	always #2 core_clk = ~core_clk;
	// Serial rate is half the core clock: one-cycle enable pulses
	always @(posedge core_clk) serial_clk_en <= #1 ~serial_clk_en;
	dcs_ctrl_status_high dut (
		.core_clk                (core_clk),
		.rst                     (rst),
		.soft_rst                (soft_rst),
		.special_single_chip     (special_single_chip),
		.device_unsecured        (device_unsecured),
		.write_ctrl_status_cmd   (write_ctrl_status_cmd),
		.read_ctrl_status_cmd    (read_ctrl_status_cmd),
		.write_data              (write_data),
		.mass_erase_cmd          (mass_erase_cmd),
		.mass_erase_done         (mass_erase_done),
		.active_debug_request    (active_debug_request),
		.active_debug_exit       (active_debug_exit),
		.stop_request            (stop_request),
		.wake_request            (wake_request),
		.ack_enabled             (ack_enabled),
		.ack_pulse               (ack_pulse),
		.serial_clk_en           (serial_clk_en),
		.access_req              (access_req),
		.bus_free                (bus_free),
		.restricted_cmd          (restricted_cmd),
		.link_cmd_valid          (link_cmd_valid),
		.read_data               (read_data),
		.read_valid              (read_valid),
		.cmd_accept              (cmd_accept),
		.active_debug_status     (active_debug_status),
		.stop_link_clk_on        (stop_link_clk_on),
		.stop_all_clk_on         (stop_all_clk_on),
		.stop_mode               (stop_mode),
		.stop_granted            (stop_granted),
		.ack_long                (ack_long),
		.bus_grant               (bus_grant),
		.bus_timeout             (bus_timeout),
		.serial_clock_select     (serial_clock_select),
		.security_change_allowed (security_change_allowed),
		.erase_pending           (erase_pending)
	);
	dcs_host_model host (
		.core_clk              (core_clk),
		.read_data             (read_data),
		.read_valid            (read_valid),
		.cmd_accept            (cmd_accept),
		.write_ctrl_status_cmd (write_ctrl_status_cmd),
		.read_ctrl_status_cmd  (read_ctrl_status_cmd),
		.write_data            (write_data),
		.link_cmd_valid        (link_cmd_valid),
		.restricted_cmd        (restricted_cmd)
	);
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic close_out;
		$display("Checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		host.rd(v);
		chk(v, 8'hC2);
		host.wr(8'hFF);
		host.rd(v);
		chk(v, 8'hEE);
		host.wr(8'h00);
		host.rd(v);
		chk(v, 8'h46);
		device_unsecured = 0;
		cyc(2);
		chk(8'(security_change_allowed), 8'h00);
		host.wr(8'h88);
		host.rd(v);
		chk(v, 8'h44);
		device_unsecured = 1;
		cyc(2);
	endtask : t_regs

	task automatic t_erase;
		mass_erase_cmd = 1;
		cyc(1);
		mass_erase_cmd = 0;
		host.wr(8'h00);
		host.rd(v);
		chk(v, 8'h47);
		mass_erase_done = 1;
		cyc(1);
		mass_erase_done = 0;
		chk(8'(erase_pending), 8'h00);
		mass_erase_cmd = 1;
		cyc(1);
		mass_erase_cmd = 0;
		soft_rst = 1;
		cyc(1);
		soft_rst = 0;
		chk({serial_clock_select, erase_pending}, 8'h00);
	endtask : t_erase

	task automatic t_active;
		active_debug_exit = 1;
		cyc(1);
		active_debug_exit = 0;
		chk(8'(active_debug_status), 8'h00);
		active_debug_request = 1;
		cyc(1);
		active_debug_request = 0;
		chk(8'(active_debug_status), 8'h00);
		host.cmd(1'b0, a);
		chk(8'(a), 8'h00);
		host.cmd(1'b1, a);
		chk(8'(a), 8'h01);
		host.wr(8'h80);
		active_debug_request = 1;
		cyc(1);
		active_debug_request = 0;
		chk(8'(active_debug_status), 8'h01);
		host.cmd(1'b0, a);
		chk(8'(a), 8'h01);
	endtask : t_active

	task automatic t_stop;
		ack_enabled = 1;
		stop_request = 1;
		cyc(1);
		stop_request = 0;
		chk({ack_long, stop_mode}, 8'h02);
		for (n = 1; n < 20 && !stop_mode; n++) cyc(1);
		chk(8'(n >= 4), 8'h01);
		chk({stop_granted, stop_mode, stop_link_clk_on, stop_all_clk_on}, 8'h0E);
		host.wr(8'hA0);
		chk(8'(stop_all_clk_on), 8'h00);
		ack_pulse = 1;
		cyc(1);
		ack_pulse = 0;
		chk(8'(ack_long), 8'h00);
		wake_request = 1;
		cyc(1);
		wake_request = 0;
		// Exit delay shows no state; wait well past two serial plus two bus cycles
		cyc(12);
		host.wr(8'hA0);
		chk(8'(stop_all_clk_on), 8'h01);
		host.wr(8'h00);
		stop_request = 1;
		cyc(1);
		stop_request = 0;
		chk({stop_mode, stop_link_clk_on}, 8'h02);
		host.cmd(1'b1, a);
		chk(8'(a), 8'h00);
		wake_request = 1;
		cyc(1);
		wake_request = 0;
		chk(8'(stop_mode), 8'h00);
	endtask : t_stop

	task automatic t_bus;
		ack_enabled = 0;
		access_req = 1;
		cyc(1);
		access_req = 0;
		chk(8'(bus_grant), 8'h01);
		host.wr(8'h88);
		ack_enabled = 1;
		access_req = 1;
		cyc(1);
		access_req = 0;
		chk(8'(bus_grant), 8'h01);
		host.wr(8'h80);
		access_req = 1;
		cyc(1);
		access_req = 0;
		for (n = 1; n < 600 && !bus_grant; n++) cyc(1);
		// Full wait counted from the edge that took the request, then the grant cycle
		chk(8'(n == BUS_WAIT_TIMEOUT_CYCLES + 1), 8'h01);
		chk(8'(bus_timeout), 8'h01);
		// A request raised after the grant cycle is taken and waits for a free cycle
		cyc(1);
		access_req = 1;
		cyc(1);
		access_req = 0;
		cyc(3);
		chk(8'(bus_grant), 8'h00);
		bus_free = 1;
		for (n = 0; n < 5 && !bus_grant; n++) cyc(1);
		chk({bus_grant, bus_timeout}, 8'h02);
	endtask : t_bus

	task automatic t_reset;
		host.wr(8'h04);
		host.rd(v);
		chk(v, 8'h46);
		special_single_chip = 0;
		rst = 1;
		cyc(2);
		rst = 0;
		cyc(2);
		host.rd(v);
		chk(v, 8'h02);
	endtask : t_reset

	initial begin
		cyc(4);
		rst = 0;
		cyc(2);
		t_regs;
		t_erase;
		t_active;
		t_stop;
		t_bus;
		t_reset;
		close_out;
	end

	initial begin
		#20000;
		bad_count++;
		close_out;
	end
endmodule : dcs_ctrl_status_high_tb
